// file: core/isp_tuning_pkg.sv
// Register map of the image-pipeline tuning bank: offsets, resets, writable masks.
// Assumes a byte-wide control port with 16-bit addresses.
package isp_tuning_pkg;

   localparam int NUM_REGS = 64;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // Offsets of the writable bytes, in index order
   localparam logic [0:NUM_REGS-1][15:0] REG_OFS = {
      16'hd490, 16'hd492, 16'hd494, 16'hd496, 16'hd498, 16'hd49a, 16'hd49c, 16'hd49d,
      16'hd49e, 16'hd4a0, 16'hd4a3, 16'hd4a4, 16'hd4a6, 16'hd4a7, 16'hd4a9, 16'hd4aa,
      16'hd4ac, 16'hd4ad, 16'hd4af, 16'hd4c0, 16'hd4c1, 16'hd540, 16'hd541, 16'hd542,
      16'hd543, 16'hd54f, 16'hd5d0, 16'hd5d1, 16'hd5e4, 16'hd5e5, 16'hd5e6, 16'hd5e7,
      16'hd5e8, 16'hd5e9, 16'hd5ea, 16'hd5eb, 16'hd5f0, 16'hd5f1, 16'hd5f2, 16'hd5f3,
      16'hd5f4, 16'hd5f5, 16'hd5f6, 16'hd5f7, 16'hd5f8, 16'hd709, 16'hd70a, 16'hd70b,
      16'hd716, 16'hd717, 16'hd718, 16'hd719, 16'hd71a, 16'hd71b, 16'hd71c, 16'hd71d,
      16'hd71e, 16'hd725, 16'hd726, 16'hd727, 16'hd728, 16'hd729, 16'hd72a, 16'hd770};

   localparam logic [0:NUM_REGS-1][7:0] REG_RST = {
      8'h10, 8'h30, 8'h70, 8'h90, 8'hd0, 8'hf0, 8'h00, 8'h10,
      8'h10, 8'h30, 8'h70, 8'h70, 8'h90, 8'h90, 8'hd0, 8'hd0,
      8'hf0, 8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h4f, 8'h00,
      8'ha9, 8'h80, 8'h10, 8'h05, 8'h00, 8'h08, 8'h05, 8'h00,
      8'h00, 8'h08, 8'h03, 8'hc0, 8'h02, 8'h00, 8'h02, 8'h00,
      8'h02, 8'h50, 8'h00, 8'h50, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   // Implemented bits; the rest hold zero and read as zero
   localparam logic [0:NUM_REGS-1][7:0] REG_MASK = {
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'h7f, 8'h07, 8'h07, 8'hff, 8'h07, 8'hff,
      8'h03, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff,
      8'hf7, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h1f, 8'h1f,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h11};

   // Indices used by the logic
   localparam int IDX_KNEE0 = 0;
   localparam int IDX_BRIGHT = 19;
   localparam int IDX_BRIGHT_ALPHA = 20;
   localparam int IDX_STEP60_HI = 21;
   localparam int IDX_STEP60_LO = 22;
   localparam int IDX_STEP50_HI = 23;
   localparam int IDX_STEP50_LO = 24;
   localparam int IDX_HYST = 25;
   localparam int IDX_FADE_START = 26;
   localparam int IDX_FADE_RANGE = 27;
   localparam int IDX_CROP0 = 28;
   localparam int IDX_UPSCALE0 = 36;
   localparam int IDX_DSC_CTRL = 40;
   localparam int IDX_DSC_FACTOR0 = 41;
   localparam int IDX_DN1_0 = 45;
   localparam int IDX_DN2_0 = 48;
   localparam int IDX_SHARP0 = 57;
   localparam int IDX_MAINS_CTRL = 63;

   localparam logic [15:0] MAINS_RESULT_OFS = 16'hd795;
   localparam logic [15:0] OVL_BASE = 16'he000;
   localparam int OVL_DEPTH = 8192;
   localparam int OVL_AW = 13;

   localparam logic [7:0] HYST_MAX = 8'h80;

   // Field positions
   localparam int BRIGHT_SIGN_BIT = 7;
   localparam int DSC_EN_BIT = 0;
   localparam int DSC_CLKO_BIT = 1;
   localparam int DSC_AUTOSYNC_BIT = 2;
   localparam int DSC_RSVD_BIT = 3;
   localparam int DSC_HPH_LSB = 4;
   localparam int DSC_VPH_LSB = 6;
   localparam int MAINS_EN_BIT = 0;
   localparam int MAINS_UPD_BIT = 4;
   localparam logic MAINS_RESULT_RST = 1'b0;

endpackage

// file: core/isp_overlay_ram.sv
// Byte-wide overlay buffer, one write port and a registered read.
// Assumes the owner never reads and writes in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module isp_overlay_ram
#(
   parameter int DEPTH = 8192,
   parameter int AW = 13
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Access port
   input wire logic wr_en,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];

   // Array kept out of reset so it maps onto a plain RAM macro
   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata <= 8'h00;
      end
      else
      begin
         rdata <= mem[addr];
      end
   end
endmodule
`default_nettype wire

// file: core/isp_tuning_register_bank.sv
// Tuning register bank of the image pipeline with its overlay buffer window.
// Assumes a one-cycle strobe port from the control interface and frame/detector events in clk.
//
// Summary of operation
// (RULE1) Brightness bytes: bit7 sign, bits6:0 magnitude
// (RULE2) Hysteresis limited to 0..128, ratio over 128
// (RULE3) 60/50 Hz flicker steps, 16-bit byte pairs
// (RULE4) Bit2: auto frame sync, else request resync
// (RULE5) Bit0 scaler enable, bit1 clock out, reset 0x02
// (RULE6) Bits7:6 vertical, 5:4 horizontal phase, bit3 reserved
// (RULE7) 16-bit down factors, high bytes default 0x50
// (RULE8) Detector enable bit0, update enable bit4
// (RULE9) Result bit0: 1 sixty, 0 fifty hertz
// (RULE10) 8192-byte overlay buffer at 0xE000..0xFFFF
// (RULE11) Software avoids overlay buffer while overlay active
// (RULE12) Crop window: 11-bit horizontal, 10-bit vertical
// (RULE13) 10-bit up factors, high 0x02, low 0x00
// (RULE14) Six contrast knees plus outputs and alphas
// (RULE15) First denoise: three 5-bit strengths, reset zero
// (RULE16) Sharpening: 6-bit mid/high strengths with alphas
// (RULE17) Second denoise: three thresholds with alpha variants
// (RULE18) High byte joined above low, unused bits zero
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module isp_tuning_register_bank
   import isp_tuning_pkg::*;
#(
   parameter int OVL_SIZE = OVL_DEPTH
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Pipeline events
   input wire logic frame_start,
   input wire logic downscale_resync_request,
   input wire logic mains_detect_valid,
   input wire logic mains_detect_is_sixty,
   // Contrast curve
   output logic [5:0][7:0] contrast_knee_in,
   output logic [5:0][7:0] contrast_out,
   output logic [7:0][7:0] contrast_out_alpha,
   // Brightness
   output logic brightness_sign,
   output logic [6:0] brightness_level,
   output logic brightness_sign_alpha,
   output logic [6:0] brightness_level_alpha,
   // Flicker
   output logic [15:0] flicker_step_sixty,
   output logic [15:0] flicker_step_fifty,
   output logic [7:0] flicker_hold_threshold,
   output logic [6:0] fade_start_mean,
   output logic [2:0] fade_range,
   // Crop window
   output logic [10:0] crop_x_offset,
   output logic [10:0] crop_x_size,
   output logic [9:0] crop_y_offset,
   output logic [9:0] crop_y_size,
   // Scalers
   output logic [9:0] upscale_h_factor,
   output logic [9:0] upscale_v_factor,
   output logic downscale_enable,
   output logic downscale_clock_out_enable,
   output logic downscale_auto_sync,
   output logic [1:0] downscale_h_phase,
   output logic [1:0] downscale_v_phase,
   output logic [15:0] downscale_h_factor,
   output logic [15:0] downscale_v_factor,
   output logic downscale_sync,
   // Luma denoise and sharpening
   output logic [2:0][4:0] luma_smooth_first_strength,
   output logic [8:0][7:0] luma_smooth_second_threshold,
   output logic [2:0][5:0] luma_edge_mid_strength,
   output logic [2:0][5:0] luma_edge_high_strength,
   // Flicker detector
   output logic mains_detect_enable,
   output logic mains_detect_update_enable,
   output logic mains_detect_sixty
);

   typedef struct packed {
      logic [0:NUM_REGS-1][7:0] regs;
      logic result;
      logic [7:0] rdata;
      logic rd_ovl;
      logic sync;
   } state_s;

   localparam state_s ST_RST = '{regs: REG_RST, result: MAINS_RESULT_RST, rdata: 8'h00, rd_ovl: 1'b0, sync: 1'b0};

   state_s st_ff;
   state_s nxt_st;
   logic ovl_hit;
   logic ovl_wr;
   logic [7:0] ovl_q;

   assign ovl_hit = (reg_addr >= OVL_BASE); // RULE10
   // No write guard while the overlay runs; keeping clear of the buffer then
   // is left to software, so the window stays a plain byte RAM
   assign ovl_wr = reg_wr && ovl_hit;

   isp_overlay_ram #(
      .DEPTH(OVL_SIZE),
      .AW(OVL_AW)
   ) u_overlay (
      .clk(clk),
      .rst(rst),
      .wr_en(ovl_wr),
      .addr(reg_addr[OVL_AW-1:0]),
      .wdata(reg_wdata),
      .rdata(ovl_q)
   );

   always_comb
   begin
      logic [7:0] wval;
      logic [7:0] dsc;
      logic [7:0] mains_ctl;
      nxt_st = st_ff;
      wval = 8'h00;
      dsc = st_ff.regs[IDX_DSC_CTRL];
      mains_ctl = st_ff.regs[IDX_MAINS_CTRL];
      nxt_st.rdata = 8'h00;
      nxt_st.rd_ovl = reg_rd && ovl_hit;
      // Decode by table walk; unmapped reads give zero, unmapped writes drop
      for (int i = 0; i < NUM_REGS; i++)
      begin
         if (reg_addr == REG_OFS[i])
         begin
            wval = reg_wdata & REG_MASK[i]; // RULE18
            if (i == IDX_HYST && reg_wdata > HYST_MAX)
            begin
               wval = HYST_MAX; // RULE2
            end
            if (reg_wr)
            begin
               nxt_st.regs[i] = wval; // RULE3 RULE7 RULE13 RULE14 RULE15 RULE16 RULE17
            end
            if (reg_rd)
            begin
               nxt_st.rdata = st_ff.regs[i];
            end
         end
      end
      if (reg_rd && reg_addr == MAINS_RESULT_OFS)
      begin
         nxt_st.rdata = {7'h00, st_ff.result}; // RULE9
      end
      // Result only follows the detector when both enables are set
      if (mains_ctl[MAINS_EN_BIT] && mains_ctl[MAINS_UPD_BIT] && mains_detect_valid)
      begin
         nxt_st.result = mains_detect_is_sixty; // RULE8 RULE9
      end
      // With the scaler enabled, free run waits for an explicit request and auto mode follows every frame; disabled, no sync
      if (!dsc[DSC_EN_BIT])
      begin
         nxt_st.sync = 1'b0;
      end
      else if (dsc[DSC_AUTOSYNC_BIT])
      begin
         nxt_st.sync = frame_start; // RULE4
      end
      else
      begin
         nxt_st.sync = downscale_resync_request; // RULE4
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= ST_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Overlay data is already a flop inside the RAM
   assign reg_rdata = st_ff.rd_ovl ? ovl_q : st_ff.rdata;

   generate
      for (genvar k = 0; k < 6; k++)
      begin : g_knee
         assign contrast_knee_in[k] = st_ff.regs[IDX_KNEE0 + k]; // RULE14
      end
   endgenerate

   assign contrast_out_alpha[0] = st_ff.regs[6];
   assign contrast_out[0] = st_ff.regs[7];
   assign contrast_out_alpha[1] = st_ff.regs[8];
   // The curve has no alpha for point two; it takes the byte of contrast_out[1]
   assign contrast_out[1] = st_ff.regs[9];
   assign contrast_out_alpha[2] = st_ff.regs[9];
   assign contrast_out[2] = st_ff.regs[10];
   assign contrast_out_alpha[3] = st_ff.regs[11];
   assign contrast_out[3] = st_ff.regs[12];
   assign contrast_out_alpha[4] = st_ff.regs[13];
   assign contrast_out[4] = st_ff.regs[14];
   assign contrast_out_alpha[5] = st_ff.regs[15];
   assign contrast_out[5] = st_ff.regs[16];
   assign contrast_out_alpha[6] = st_ff.regs[17];
   assign contrast_out_alpha[7] = st_ff.regs[18];

   assign brightness_sign = st_ff.regs[IDX_BRIGHT][BRIGHT_SIGN_BIT]; // RULE1
   assign brightness_level = st_ff.regs[IDX_BRIGHT][6:0]; // RULE1
   assign brightness_sign_alpha = st_ff.regs[IDX_BRIGHT_ALPHA][BRIGHT_SIGN_BIT]; // RULE1
   assign brightness_level_alpha = st_ff.regs[IDX_BRIGHT_ALPHA][6:0]; // RULE1

   assign flicker_step_sixty = {st_ff.regs[IDX_STEP60_HI], st_ff.regs[IDX_STEP60_LO]}; // RULE3
   assign flicker_step_fifty = {st_ff.regs[IDX_STEP50_HI], st_ff.regs[IDX_STEP50_LO]}; // RULE3
   assign flicker_hold_threshold = st_ff.regs[IDX_HYST]; // RULE2
   assign fade_start_mean = st_ff.regs[IDX_FADE_START][6:0];
   assign fade_range = st_ff.regs[IDX_FADE_RANGE][2:0];

   assign crop_x_offset = {st_ff.regs[IDX_CROP0][2:0], st_ff.regs[IDX_CROP0 + 1]}; // RULE12
   assign crop_x_size = {st_ff.regs[IDX_CROP0 + 2][2:0], st_ff.regs[IDX_CROP0 + 3]}; // RULE12
   assign crop_y_offset = {st_ff.regs[IDX_CROP0 + 4][1:0], st_ff.regs[IDX_CROP0 + 5]}; // RULE12
   assign crop_y_size = {st_ff.regs[IDX_CROP0 + 6][1:0], st_ff.regs[IDX_CROP0 + 7]}; // RULE12

   assign upscale_h_factor = {st_ff.regs[IDX_UPSCALE0][1:0], st_ff.regs[IDX_UPSCALE0 + 1]}; // RULE13
   assign upscale_v_factor = {st_ff.regs[IDX_UPSCALE0 + 2][1:0], st_ff.regs[IDX_UPSCALE0 + 3]}; // RULE13

   assign downscale_enable = st_ff.regs[IDX_DSC_CTRL][DSC_EN_BIT]; // RULE5
   assign downscale_clock_out_enable = st_ff.regs[IDX_DSC_CTRL][DSC_CLKO_BIT]; // RULE5
   assign downscale_auto_sync = st_ff.regs[IDX_DSC_CTRL][DSC_AUTOSYNC_BIT]; // RULE4
   assign downscale_h_phase = st_ff.regs[IDX_DSC_CTRL][DSC_HPH_LSB +: 2]; // RULE6
   assign downscale_v_phase = st_ff.regs[IDX_DSC_CTRL][DSC_VPH_LSB +: 2]; // RULE6
   assign downscale_h_factor = {st_ff.regs[IDX_DSC_FACTOR0], st_ff.regs[IDX_DSC_FACTOR0 + 1]}; // RULE7
   assign downscale_v_factor = {st_ff.regs[IDX_DSC_FACTOR0 + 2], st_ff.regs[IDX_DSC_FACTOR0 + 3]}; // RULE7
   assign downscale_sync = st_ff.sync;

   generate
      for (genvar j = 0; j < 3; j++)
      begin : g_luma
         assign luma_smooth_first_strength[j] = st_ff.regs[IDX_DN1_0 + j][4:0]; // RULE15
         // Mid alphas are f2.6 fixed point; carried as raw bits
         assign luma_edge_mid_strength[j] = st_ff.regs[IDX_SHARP0 + j][5:0]; // RULE16
         assign luma_edge_high_strength[j] = st_ff.regs[IDX_SHARP0 + 3 + j][5:0]; // RULE16
      end
      for (genvar t = 0; t < 9; t++)
      begin : g_dn2
         assign luma_smooth_second_threshold[t] = st_ff.regs[IDX_DN2_0 + t]; // RULE17
      end
   endgenerate

   assign mains_detect_enable = st_ff.regs[IDX_MAINS_CTRL][MAINS_EN_BIT]; // RULE8
   assign mains_detect_update_enable = st_ff.regs[IDX_MAINS_CTRL][MAINS_UPD_BIT]; // RULE8
   assign mains_detect_sixty = st_ff.result; // RULE9

   property p_bright_split;
      @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == REG_OFS[IDX_BRIGHT]
      |=> brightness_sign == $past(reg_wdata[7]) && brightness_level == $past(reg_wdata[6:0]);
   endproperty
   a_bright_split: assert property (p_bright_split) else $error("brightness fields wrong"); // RULE1

   property p_hyst_limit;
      @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == REG_OFS[IDX_HYST] && reg_wdata > 8'h80 |=> flicker_hold_threshold == 8'h80;
   endproperty
   a_hyst_limit: assert property (p_hyst_limit) else $error("hysteresis above 128"); // RULE2

   property p_step_lo;
      @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == REG_OFS[IDX_STEP60_LO]
      |=> flicker_step_sixty[7:0] == $past(reg_wdata) && $stable(flicker_step_sixty[15:8]);
   endproperty
   a_step_lo: assert property (p_step_lo) else $error("sixty step low byte lost"); // RULE3

   property p_auto_sync;
      @(posedge clk) disable iff (rst)
      downscale_enable && downscale_auto_sync && frame_start && !reg_wr |=> downscale_sync;
   endproperty
   a_auto_sync: assert property (p_auto_sync) else $error("no sync on frame"); // RULE4

   property p_free_run;
      @(posedge clk) disable iff (rst)
      !downscale_auto_sync && !downscale_resync_request && !reg_wr |=> !downscale_sync;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free run resynced"); // RULE4

   property p_dsc_reserved;
      @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == REG_OFS[IDX_DSC_CTRL] |=> reg_rdata[DSC_RSVD_BIT] == 1'b0;
   endproperty
   a_dsc_reserved: assert property (p_dsc_reserved) else $error("reserved bit set"); // RULE6

   property p_result_hold;
      @(posedge clk) disable iff (rst)
      !mains_detect_update_enable ##1 !mains_detect_update_enable |-> $stable(mains_detect_sixty);
   endproperty
   a_result_hold: assert property (p_result_hold) else $error("result moved without update"); // RULE8

   property p_result_update;
      @(posedge clk) disable iff (rst)
      mains_detect_enable && mains_detect_update_enable && mains_detect_valid
      |=> mains_detect_sixty == $past(mains_detect_is_sixty);
   endproperty
   a_result_update: assert property (p_result_update) else $error("result not captured"); // RULE9

   property p_ovl_readback;
      logic [15:0] a;
      logic [7:0] d;
      @(posedge clk) disable iff (rst)
      (reg_wr && reg_addr >= OVL_BASE, a = reg_addr, d = reg_wdata)
      ##1 (reg_rd && reg_addr == a) |=> reg_rdata == d;
   endproperty
   a_ovl_readback: assert property (p_ovl_readback) else $error("overlay byte lost"); // RULE10

   property p_crop_high_zero;
      @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == REG_OFS[IDX_CROP0] |=> reg_rdata[7:3] == 5'h00;
   endproperty
   a_crop_high_zero: assert property (p_crop_high_zero) else $error("unused high bits set"); // RULE12 RULE18

   // A hole inside the knee block must read back as zero
   property p_unmapped_zero;
      @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == 16'hd491 |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

   c_auto_sync: cover property (@(posedge clk) disable iff (rst) downscale_auto_sync && downscale_sync);
   c_sixty: cover property (@(posedge clk) disable iff (rst) $rose(mains_detect_sixty));
   c_ovl_rd: cover property (@(posedge clk) disable iff (rst) reg_rd && reg_addr >= OVL_BASE);
   c_hyst_clip: cover property (@(posedge clk) disable iff (rst) reg_wr && reg_addr == REG_OFS[IDX_HYST]
      && reg_wdata > 8'h80);

endmodule
`default_nettype wire

// file: bench/isp_tuning_register_bank_test.sv
// Self-checking bench for the tuning register bank and its overlay window.
// Assumes the bank's strobe port with read data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module isp_tuning_register_bank_test;
   import isp_tuning_pkg::*;

   logic clk, rst, reg_wr, reg_rd;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic frame_start, downscale_resync_request, mains_detect_valid, mains_detect_is_sixty;
   logic [5:0][7:0] contrast_knee_in, contrast_out;
   logic [7:0][7:0] contrast_out_alpha;
   logic brightness_sign, brightness_sign_alpha;
   logic [6:0] brightness_level, brightness_level_alpha, fade_start_mean;
   logic [15:0] flicker_step_sixty, flicker_step_fifty, downscale_h_factor, downscale_v_factor;
   logic [7:0] flicker_hold_threshold;
   logic [2:0] fade_range;
   logic [10:0] crop_x_offset, crop_x_size;
   logic [9:0] crop_y_offset, crop_y_size, upscale_h_factor, upscale_v_factor;
   logic downscale_enable, downscale_clock_out_enable, downscale_auto_sync, downscale_sync;
   logic [1:0] downscale_h_phase, downscale_v_phase;
   logic [2:0][4:0] luma_smooth_first_strength;
   logic [8:0][7:0] luma_smooth_second_threshold;
   logic [2:0][5:0] luma_edge_mid_strength, luma_edge_high_strength;
   logic mains_detect_enable, mains_detect_update_enable, mains_detect_sixty;
   int errors = 0;
   int total_checks = 0;

   isp_tuning_register_bank dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .frame_start, .downscale_resync_request, .mains_detect_valid, .mains_detect_is_sixty,
      .contrast_knee_in, .contrast_out, .contrast_out_alpha, .brightness_sign, .brightness_level,
      .brightness_sign_alpha, .brightness_level_alpha, .flicker_step_sixty, .flicker_step_fifty,
      .flicker_hold_threshold, .fade_start_mean, .fade_range, .crop_x_offset, .crop_x_size,
      .crop_y_offset, .crop_y_size, .upscale_h_factor, .upscale_v_factor, .downscale_enable,
      .downscale_clock_out_enable, .downscale_auto_sync, .downscale_h_phase, .downscale_v_phase,
      .downscale_h_factor, .downscale_v_factor, .downscale_sync, .luma_smooth_first_strength,
      .luma_smooth_second_threshold, .luma_edge_mid_strength, .luma_edge_high_strength,
      .mains_detect_enable, .mains_detect_update_enable, .mains_detect_sixty);

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Strobes drop one edge before the next task raises them again
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   task automatic settle;
      @(posedge clk);
      #1;
   endtask

   task automatic sync_pulse(input logic f, input logic r, input logic e);
      @(posedge clk);
      frame_start <= f;
      downscale_resync_request <= r;
      @(posedge clk);
      frame_start <= 1'b0;
      downscale_resync_request <= 1'b0;
      #1;
      check(16'(downscale_sync), 16'(e));
      settle();
      check(16'(downscale_sync), 16'h0000);
   endtask

   task automatic detect(input logic s, input logic e);
      @(posedge clk);
      mains_detect_valid <= 1'b1;
      mains_detect_is_sixty <= s;
      @(posedge clk);
      mains_detect_valid <= 1'b0;
      #1;
      check(16'(mains_detect_sixty), 16'(e));
   endtask

   task automatic t_reset;
      for (int i = 0; i < NUM_REGS; i++)
      begin
         rd(REG_OFS[i], d);
         check(16'(d), 16'(REG_RST[i]));
      end
      check(flicker_step_sixty, 16'h004f);
      check(flicker_step_fifty, 16'h00a9);
      check(16'({downscale_enable, downscale_clock_out_enable}), 16'h0001);
      check(downscale_h_factor, 16'h5000);
      check(downscale_v_factor, 16'h5000);
      check(16'(upscale_h_factor), 16'h0200);
      check(16'(upscale_v_factor), 16'h0200);
      check(16'(contrast_knee_in[5]), 16'h00f0);
      check(16'(contrast_out_alpha[7]), 16'h00ff);
      check(16'(luma_smooth_first_strength), 16'h0000);
      check(16'(|luma_smooth_second_threshold), 16'h0000);
      check(16'({mains_detect_enable, mains_detect_update_enable}), 16'h0000);
      check(16'(fade_start_mean), 16'h0010);
      check(16'(fade_range), 16'h0005);
      check(16'(crop_x_size), 16'h0500);
      check(16'(crop_y_offset), 16'h0008);
      rd(MAINS_RESULT_OFS, d);
      check(16'(d), 16'h0000);
      wr(16'hd491, 8'hff);
      rd(16'hd491, d);
      check(16'(d), 16'h0000);
      rd(16'hd490, d);
      check(16'(d), 16'h0010);
      $display("reset values test done");
   endtask

   task automatic t_brightness;
      wr(16'hd4c0, 8'h85);
      wr(16'hd4c1, 8'h7f);
      settle();
      check(16'({brightness_sign, brightness_level}), 16'h0085);
      check(16'({brightness_sign_alpha, brightness_level_alpha}), 16'h007f);
      $display("brightness test done");
   endtask

   task automatic t_hysteresis;
      logic [7:0] vals [4] = '{8'h00, 8'h80, 8'h81, 8'hff};
      logic [7:0] exps [4] = '{8'h00, 8'h80, 8'h80, 8'h80};
      for (int i = 0; i < 4; i++)
      begin
         wr(16'hd54f, vals[i]);
         rd(16'hd54f, d);
         check(16'(d), 16'(exps[i]));
         check(16'(flicker_hold_threshold), 16'(exps[i]));
      end
      $display("hysteresis test done");
   endtask

   task automatic t_pairs;
      wr(16'hd540, 8'h12);
      wr(16'hd541, 8'h34);
      wr(16'hd542, 8'hab);
      wr(16'hd543, 8'hcd);
      wr(16'hd5e4, 8'hff);
      wr(16'hd5e5, 8'hff);
      wr(16'hd5ea, 8'hff);
      wr(16'hd5f2, 8'hff);
      wr(16'hd5f5, 8'ha5);
      wr(16'hd5f6, 8'h5a);
      settle();
      check(flicker_step_sixty, 16'h1234);
      check(flicker_step_fifty, 16'habcd);
      check(16'(crop_x_offset), 16'h07ff);
      check(16'(crop_y_size), 16'h03c0);
      check(16'(upscale_v_factor), 16'h0300);
      check(downscale_h_factor, 16'ha55a);
      rd(16'hd5e4, d);
      check(16'(d), 16'h0007);
      rd(16'hd5ea, d);
      check(16'(d), 16'h0003);
      $display("byte pair test done");
   endtask

   task automatic t_scaler;
      wr(16'hd5f4, 8'hff);
      rd(16'hd5f4, d);
      check(16'(d), 16'h00f7);
      wr(16'hd5f4, 8'h61);
      settle();
      check(16'({downscale_v_phase, downscale_h_phase, downscale_auto_sync, downscale_clock_out_enable,
         downscale_enable}), 16'h0031);
      wr(16'hd5f4, 8'h01);
      sync_pulse(1'b1, 1'b0, 1'b0);
      sync_pulse(1'b0, 1'b1, 1'b1);
      wr(16'hd5f4, 8'h05);
      sync_pulse(1'b1, 1'b0, 1'b1);
      sync_pulse(1'b0, 1'b1, 1'b0);
      wr(16'hd5f4, 8'h04);
      sync_pulse(1'b1, 1'b1, 1'b0);
      $display("down scaler test done");
   endtask

   task automatic t_detector;
      wr(16'hd770, 8'h01);
      detect(1'b1, 1'b0);
      wr(16'hd770, 8'h10);
      detect(1'b1, 1'b0);
      wr(16'hd770, 8'hff);
      rd(16'hd770, d);
      check(16'(d), 16'h0011);
      detect(1'b1, 1'b1);
      wr(MAINS_RESULT_OFS, 8'h00);
      rd(MAINS_RESULT_OFS, d);
      check(16'(d), 16'h0001);
      detect(1'b0, 1'b0);
      rd(MAINS_RESULT_OFS, d);
      check(16'(d), 16'h0000);
      $display("flicker detector test done");
   endtask

   // Overlay engine is never active here, so buffer access is permitted
   task automatic t_overlay;
      wr(16'he000, 8'h11);
      wr(16'hffff, 8'h22);
      wr(16'he005, 8'hab);
      rd(16'he005, d);
      check(16'(d), 16'h00ab);
      rd(16'he000, d);
      check(16'(d), 16'h0011);
      rd(16'hffff, d);
      check(16'(d), 16'h0022);
      // Write then read the same byte with no gap between the strobes
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= 16'hf00d;
      reg_wdata <= 8'h5c;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check(16'(reg_rdata), 16'h005c);
      $display("overlay buffer test done");
   endtask

   task automatic t_luma;
      wr(16'hd709, 8'hff);
      wr(16'hd70b, 8'h0a);
      wr(16'hd716, 8'hc3);
      wr(16'hd71e, 8'h3c);
      wr(16'hd725, 8'hff);
      wr(16'hd72a, 8'h15);
      wr(16'hd490, 8'hab);
      wr(16'hd4a0, 8'h77);
      settle();
      check(16'(luma_smooth_first_strength[0]), 16'h001f);
      check(16'(luma_smooth_first_strength[2]), 16'h000a);
      check(16'(luma_smooth_second_threshold[0]), 16'h00c3);
      check(16'(luma_smooth_second_threshold[8]), 16'h003c);
      check(16'(luma_edge_mid_strength[0]), 16'h003f);
      check(16'(luma_edge_high_strength[2]), 16'h0015);
      check(16'(contrast_knee_in[0]), 16'h00ab);
      check(16'({contrast_out[1], contrast_out_alpha[2]}), 16'h7777);
      rd(16'hd725, d);
      check(16'(d), 16'h003f);
      $display("luma and contrast test done");
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end

   initial
   begin
      rst = 1'b1;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      frame_start = 1'b0;
      downscale_resync_request = 1'b0;
      mains_detect_valid = 1'b0;
      mains_detect_is_sixty = 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_brightness();
      t_hysteresis();
      t_pairs();
      t_scaler();
      t_detector();
      t_overlay();
      t_luma();
      conclude();
   end
endmodule
`default_nettype wire
